// >>> pkg/dec_jump_pkg.sv
// shared constants and carrier types for the decrement/jump executor
package dec_jump_pkg;
  localparam int          DATA_W      = 8;
  localparam int          INSN_W      = 16;
  localparam int          PC_W        = 16;
  localparam int          LIT_W       = 13;
  // opcode fields
  localparam logic [3:0]  OP_DEC      = 4'h0;
  localparam logic [3:0]  OP_DEC_SZ   = 4'h1;
  localparam logic [3:0]  OP_DEC_SNZ  = 4'h2;
  localparam logic [2:0]  SUB_DEC     = 3'h3;
  localparam logic [2:0]  OP_JUMP     = 3'h6;
  localparam int          TOP_HI      = 15;
  localparam int          TOP_LO      = 12;
  localparam int          SUB_HI      = 11;
  localparam int          SUB_LO      = 9;
  localparam int          DEST_BIT    = 8;
  localparam int          JMP_HI      = 15;
  localparam int          JMP_LO      = 13;
  localparam int          LATH_LIT_HI = 12;
  localparam int          LATH_LIT_LO = 8;
  localparam logic [7:0]  ONE8        = 8'h01;
  localparam logic [7:0]  ZERO8       = 8'h00;
  localparam logic [7:0]  SIGN8       = 8'h80;
  localparam int          NIB_W       = 4;
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [7:0]  W_RST       = 8'h00;
  // status flag positions inside the 4-bit flag word
  localparam int          FLG_C       = 0;
  localparam int          FLG_DC      = 1;
  localparam int          FLG_Z       = 2;
  localparam int          FLG_OV      = 3;
  localparam logic [3:0]  FLG_RST     = 4'h0;

  typedef struct packed {
    logic       wrEn;
    logic [7:0] addr;
    logic [7:0] data;
  } file_wr_t;

  typedef struct packed {
    logic       overflowFlag;
    logic       zero;
    logic       digitCarryFlag;
    logic       carry;
  } flags_t;
endpackage : dec_jump_pkg

// >>> src/dec_jump_exec.sv
// decode and four-phase execution of decrement, decrement-skip and jump
module dec_jump_exec #(
  parameter int ADDR_W = 8
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic [15:0]                 insnWord,
  input  wire logic                        insnValid,
  input  wire logic [7:0]                  fileRdData,
  output logic      [7:0]                  fileRdAddr,
  output logic                             fileRdEn,
  output dec_jump_pkg::file_wr_t           fileWr,
  output logic      [7:0]                  working_register,
  output logic      [15:0]                 progCounter,
  output logic      [7:0]                  program_counter_high_latch,
  output dec_jump_pkg::flags_t             statusFlags,
  output logic                             flushPrefetch,
  output logic                             insnRetire,
  output logic                             insnUnknown,
  output logic      [1:0]                  qPhase
);
  // the file port is fixed at one byte of address
  if (ADDR_W != dec_jump_pkg::DATA_W) begin : g_bad_addr_w
    $error("ADDR_W must equal the file address width");
  end

  typedef enum logic [3:0] {
    Q1 = 4'b0001,
    Q2 = 4'b0010,
    Q3 = 4'b0100,
    Q4 = 4'b1000
  } phase_t;

  // kind of the instruction in flight; none also covers forced nops
  typedef enum logic [4:0] {
    K_NONE  = 5'b00001,
    K_DEC   = 5'b00010,
    K_DECZ  = 5'b00100,
    K_DECNZ = 5'b01000,
    K_JUMP  = 5'b10000
  } kind_t;

  phase_t      phase_ff;
  kind_t       kind_ff;
  logic        forcedNop_ff;
  logic [15:0] insn_ff;
  logic [7:0]  operand_ff;
  logic [7:0]  result_ff;
  logic [7:0]  working_register_ff;
  logic [15:0] pc_ff;
  logic [7:0]  lath_ff;
  dec_jump_pkg::flags_t     flags_ff;
  dec_jump_pkg::file_wr_t   fwr_ff;
  logic        flush_ff;
  logic        retire_ff;
  logic        unknown_ff;
  logic        skipPend_ff;
  kind_t       nxt_kind;
  logic [7:0]  nxt_result;
  logic        destFile;
  logic [3:0]  topNib;
  logic [2:0]  subOp;
  logic        isDecKind;
  logic        skipTaken;
  logic [1:0]  phaseNum;
  dec_jump_pkg::flags_t     nxt_flags;

  assign topNib   = insnWord[dec_jump_pkg::TOP_HI:dec_jump_pkg::TOP_LO];
  assign subOp    = insnWord[dec_jump_pkg::SUB_HI:dec_jump_pkg::SUB_LO];
  assign destFile = insn_ff[dec_jump_pkg::DEST_BIT];

  // q-phase sequencer, free running
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_ff <= Q1;
    end else begin
      unique case (phase_ff)
        Q1: phase_ff <= Q2;
        Q2: phase_ff <= Q3;
        Q3: phase_ff <= Q4;
        Q4: phase_ff <= Q1;
        // a corrupted code falls back to q1
        default: phase_ff <= Q1;
      endcase
    end
  end

  // opcode decode, only meaningful in q1
  // jump owns the whole 110 top, so it is tested first
  always_comb begin
    nxt_kind = K_NONE;
    if (insnWord[dec_jump_pkg::JMP_HI:dec_jump_pkg::JMP_LO]
        == dec_jump_pkg::OP_JUMP) begin
      nxt_kind = K_JUMP;
    end else if (subOp == dec_jump_pkg::SUB_DEC) begin
      unique case (topNib)
        dec_jump_pkg::OP_DEC:     nxt_kind = K_DEC;
        dec_jump_pkg::OP_DEC_SZ:  nxt_kind = K_DECZ;
        dec_jump_pkg::OP_DEC_SNZ: nxt_kind = K_DECNZ;
        default:                  nxt_kind = K_NONE;
      endcase
    end
  end

  // q1 latch of instruction; a pending skip or jump turns it into a nop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      kind_ff      <= K_NONE;
      insn_ff      <= '0;
      forcedNop_ff <= 1'b0;
    end else if (phase_ff == Q1) begin
      insn_ff      <= insnWord;
      forcedNop_ff <= skipPend_ff;
      kind_ff      <= (skipPend_ff || !insnValid) ? K_NONE : nxt_kind;
    end
  end

  // other groups are left to their own executors; flag them, do nothing
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      unknown_ff <= 1'b0;
    end else if (phase_ff == Q1) begin
      unknown_ff <= insnValid && !skipPend_ff && nxt_kind == K_NONE;
    end
  end

  // only the three decrement kinds touch the file
  assign isDecKind  = kind_ff == K_DEC || kind_ff == K_DECZ ||
                      kind_ff == K_DECNZ;

  // q2 file read
  assign fileRdAddr = insn_ff[dec_jump_pkg::DATA_W-1:0];
  assign fileRdEn   = phase_ff == Q2 && isDecKind;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      operand_ff <= dec_jump_pkg::ZERO8;
    end else if (fileRdEn) begin
      operand_ff <= fileRdData;
    end
  end

  // q3 compute
  // wraps to ff on zero; the borrow shows up in the carry flag
  assign nxt_result = operand_ff - dec_jump_pkg::ONE8;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      result_ff <= dec_jump_pkg::ZERO8;
    end else if (phase_ff == Q3) begin
      result_ff <= nxt_result;
    end
  end

  // q4 write back into the file; the strobe is a one-cycle pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fwr_ff <= '0;
    end else begin
      fwr_ff.wrEn <= 1'b0;
      if (phase_ff == Q4 && isDecKind && destFile) begin
        fwr_ff.wrEn <= 1'b1;
        fwr_ff.addr <= insn_ff[dec_jump_pkg::DATA_W-1:0];
        fwr_ff.data <= result_ff;
      end
    end
  end

  // q4 write into the working register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      working_register_ff <= dec_jump_pkg::W_RST;
    end else if (phase_ff == Q4 && isDecKind && !destFile) begin
      working_register_ff <= result_ff;
    end
  end

  // flags of a decrement; carry is borrow-inverted, set when no borrow
  always_comb begin
    nxt_flags.carry          = operand_ff != dec_jump_pkg::ZERO8;
    nxt_flags.digitCarryFlag =
      operand_ff[dec_jump_pkg::NIB_W-1:0] != '0;
    nxt_flags.zero           = result_ff == dec_jump_pkg::ZERO8;
    nxt_flags.overflowFlag   = operand_ff == dec_jump_pkg::SIGN8;
  end

  // only the plain decrement touches the flags; skips must not
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flags_ff <= dec_jump_pkg::flags_t'(dec_jump_pkg::FLG_RST);
    end else if (phase_ff == Q4 && kind_ff == K_DEC) begin
      flags_ff <= nxt_flags;
    end
  end

  // does the executing instruction throw away the prefetched one
  always_comb begin
    unique case (kind_ff)
      K_DECZ: begin
        skipTaken = result_ff == dec_jump_pkg::ZERO8;
      end
      K_DECNZ: begin
        skipTaken = result_ff != dec_jump_pkg::ZERO8;
      end
      K_JUMP: begin
        skipTaken = 1'b1;
      end
      K_NONE, K_DEC: begin
        skipTaken = 1'b0;
      end
      default: begin
        skipTaken = 1'b0;
      end
    endcase
  end

  // skip decision at q4, consumed at the next q1
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      skipPend_ff <= 1'b0;
    end else if (phase_ff == Q4) begin
      skipPend_ff <= skipTaken;
    end
  end

  // flush pulse tells the fetch side to drop its prefetched word
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= phase_ff == Q4 && skipTaken;
    end
  end

  // jump: pc low bits from literal, upper bits kept within the 8k page
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc_ff <= dec_jump_pkg::PC_RST;
    end else if (phase_ff == Q3 && kind_ff == K_JUMP) begin
      pc_ff[dec_jump_pkg::LIT_W-1:0] <=
        insn_ff[dec_jump_pkg::LIT_W-1:0];
    end else if (phase_ff == Q4 && kind_ff != K_JUMP) begin
      // sequential advance; a forced nop still consumes its slot
      pc_ff <= pc_ff + 16'h0001;
    end
  end

  // latch refresh; page bits taken from the pc, which the jump keeps
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lath_ff <= dec_jump_pkg::ZERO8;
    end else if (phase_ff == Q3 && kind_ff == K_JUMP) begin
      lath_ff <= {pc_ff[dec_jump_pkg::PC_W-1:dec_jump_pkg::LIT_W],
                  insn_ff[dec_jump_pkg::LATH_LIT_HI:
                          dec_jump_pkg::LATH_LIT_LO]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      retire_ff <= 1'b0;
    end else begin
      // a forced nop never counts as executed
      retire_ff <= phase_ff == Q4 && !forcedNop_ff && kind_ff != K_NONE;
    end
  end

  // registered state straight to the ports
  assign fileWr                     = fwr_ff;
  assign working_register           = working_register_ff;
  assign progCounter                = pc_ff;
  assign program_counter_high_latch = lath_ff;
  assign statusFlags                = flags_ff;
  assign flushPrefetch              = flush_ff;
  assign insnRetire                 = retire_ff;
  assign insnUnknown                = unknown_ff;
  // phase number for the outside world, quarter 0 to 3
  always_comb begin
    unique case (phase_ff)
      Q1: phaseNum = 2'h0;
      Q2: phaseNum = 2'h1;
      Q3: phaseNum = 2'h2;
      Q4: phaseNum = 2'h3;
      default: phaseNum = 2'h0;
    endcase
  end

  assign qPhase = phaseNum;
endmodule : dec_jump_exec

// >>> verif/dec_jump_exec_asserts.sv
// bound assertions for the decrement and jump executor
module dec_jump_exec_asserts (
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  input wire logic [15:0]            insnWord,
  input wire logic                   insnValid,
  input wire logic [7:0]             fileRdData,
  input wire logic                   fileRdEn,
  input wire dec_jump_pkg::file_wr_t fileWr,
  input wire logic [7:0]             working_register,
  input wire logic [15:0]            progCounter,
  input wire logic [7:0]             program_counter_high_latch,
  input wire dec_jump_pkg::flags_t   statusFlags,
  input wire logic                   flushPrefetch,
  input wire logic                   insnRetire,
  input wire logic [1:0]             qPhase
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // the slot right after a flush is a forced nop, never taken
  wire logic take = qPhase == 2'h0 && insnValid && !flushPrefetch;
  wire logic isDec = insnWord[15:12] <= 4'h2 && insnWord[11:9] == 3'h3;
  sequence s_dec(logic d);
    take && isDec && insnWord[8] == d;
  endsequence
  sequence s_op(logic [3:0] op);
    take && isDec && insnWord[15:12] == op;
  endsequence
  sequence s_jmp;
    take && insnWord[15:13] == 3'h6;
  endsequence
  property p_step;
    rst_n && qPhase != 2'h3 |=> qPhase == $past(qPhase) + 2'h1;
  endproperty
  a_step: assert property (p_step) else $error("phase step");
  property p_wrap;
    qPhase == 2'h3 |=> qPhase == 2'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("phase wrap");
  property p_rd;
    fileRdEn |-> qPhase == 2'h1;
  endproperty
  a_rd: assert property (p_rd) else $error("read phase");
  property p_working_register;
    s_dec(1'b0) |-> ##4 !fileWr.wrEn &&
      working_register == $past(fileRdData, 3) - 8'h01;
  endproperty
  a_working_register: assert property (p_working_register) else $error("working_register dest");
  property p_file;
    s_dec(1'b1) |-> ##4 fileWr.wrEn && fileWr.addr == $past(insnWord[7:0], 4)
      && fileWr.data == $past(fileRdData, 3) - 8'h01;
  endproperty
  a_file: assert property (p_file) else $error("file dest");
  property p_plain;
    s_op(4'h0) |-> ##4 !flushPrefetch &&
      statusFlags.zero == ($past(fileRdData, 3) == 8'h01);
  endproperty
  a_plain: assert property (p_plain) else $error("plain dec");
  property p_skz;
    s_op(4'h1) |-> ##4 flushPrefetch == ($past(fileRdData, 3) == 8'h01);
  endproperty
  a_skz: assert property (p_skz) else $error("skip zero");
  property p_sknz;
    s_op(4'h2) |-> ##4 flushPrefetch == ($past(fileRdData, 3) != 8'h01);
  endproperty
  a_sknz: assert property (p_sknz) else $error("skip nonzero");
  property p_keep;
    (s_op(4'h1) or s_op(4'h2) or s_jmp) |->
      ##4 statusFlags == $past(statusFlags, 4);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_jump;
    s_jmp |-> ##4 flushPrefetch &&
      progCounter[12:0] == $past(insnWord[12:0], 4) &&
      progCounter[15:13] == $past(progCounter[15:13], 4) &&
      program_counter_high_latch ==
        {progCounter[15:13], $past(insnWord[12:8], 4)};
  endproperty
  a_jump: assert property (p_jump) else $error("jump");
  property p_nop;
    flushPrefetch |-> ##4 !insnRetire;
  endproperty
  a_nop: assert property (p_nop) else $error("nop retired");
endmodule : dec_jump_exec_asserts

bind dec_jump_exec dec_jump_exec_asserts u_dec_jump_exec_asserts (
  .clk_sys(clk_sys), .rst_n(rst_n), .insnWord(insnWord),
  .insnValid(insnValid), .fileRdData(fileRdData), .fileRdEn(fileRdEn),
  .fileWr(fileWr), .working_register(working_register),
  .progCounter(progCounter), .statusFlags(statusFlags),
  .program_counter_high_latch(program_counter_high_latch),
  .flushPrefetch(flushPrefetch), .insnRetire(insnRetire), .qPhase(qPhase)
);

// >>> verif/tb_dec_jump_exec.sv
// self-checking bench for the decrement and jump executor
module tb_dec_jump_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_sys    = 1'b0;
  logic                   rst_n      = 1'b0;
  logic [15:0]            insnWord   = 16'h0000;
  logic                   insnValid  = 1'b0;
  logic [7:0]             fileRdData = 8'h00;
  logic [7:0]             fileRdAddr, working_register, latch;
  logic [15:0]            progCounter;
  logic                   fileRdEn, flushPrefetch, insnRetire, insnUnknown;
  logic [1:0]             qPhase;
  dec_jump_pkg::file_wr_t fileWr;
  dec_jump_pkg::flags_t   statusFlags;
  int                     fails      = 0;
  int                     num_checks = 0;
  int                     cyc        = 0;

  dec_jump_exec u_dec_jump_exec (
    .clk_sys(clk_sys), .rst_n(rst_n), .insnWord(insnWord),
    .insnValid(insnValid), .fileRdData(fileRdData),
    .fileRdAddr(fileRdAddr), .fileRdEn(fileRdEn), .fileWr(fileWr),
    .working_register(working_register), .progCounter(progCounter),
    .program_counter_high_latch(latch), .statusFlags(statusFlags),
    .flushPrefetch(flushPrefetch), .insnRetire(insnRetire),
    .insnUnknown(insnUnknown), .qPhase(qPhase)
  );

  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // a hang ends the run as a failure
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(logic [16:0] seen, logic [16:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // present one word in Q1, then settle in the following Q1 cycle
  task automatic issue(logic [15:0] w, logic [7:0] v);
    do @(negedge clk_sys); while (qPhase !== 2'h3);
    @(posedge clk_sys);
    insnWord   <= w;
    insnValid  <= 1'b1;
    fileRdData <= v;
    @(posedge clk_sys);
    insnValid  <= 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : issue

  task automatic t_dec();
    issue(16'h0735, 8'h00);
    chk(fileWr, 17'h135ff);
    chk(17'(working_register), 17'h00000);
    chk(17'(statusFlags), 17'h00000);
    chk(17'(fileRdAddr), 17'h00035);
    issue(16'h0635, 8'h80);
    chk(17'(working_register), 17'h0007f);
    chk(17'(statusFlags), 17'h00009);
    chk(17'({fileWr.wrEn, flushPrefetch, insnRetire}), 17'h1);
    $display("t_dec done");
  endtask : t_dec

  task automatic t_skip_zero();
    issue(16'h1735, 8'h01);
    chk(fileWr, 17'h13500);
    chk(17'(flushPrefetch), 17'h1);
    issue(16'h1635, 8'h05);
    chk(17'(working_register), 17'h00004);
    chk(17'(flushPrefetch), 17'h0);
    chk(17'(statusFlags), 17'h00009);
    $display("t_skip_zero done");
  endtask : t_skip_zero

  task automatic t_skip_nonzero();
    issue(16'h2635, 8'h05);
    chk(17'({working_register, flushPrefetch}), 17'h009);
    issue(16'h2635, 8'h01);
    chk(17'({working_register, flushPrefetch}), 17'h000);
    chk(17'(statusFlags), 17'h00009);
    $display("t_skip_nonzero done");
  endtask : t_skip_nonzero

  task automatic t_jump();
    issue(16'hdabc, 8'h00);
    chk(17'(progCounter), 17'h01abc);
    chk(17'(latch), 17'h0001a);
    chk(17'(flushPrefetch), 17'h1);
    // run the pc into the second page so the kept bits are not all zero
    while (progCounter < 16'h2000) @(negedge clk_sys);
    issue(16'hc005, 8'h00);
    chk(17'(progCounter), 17'h02005);
    chk(17'(latch), 17'h00020);
    chk(17'(statusFlags), 17'h00009);
    $display("t_jump done");
  endtask : t_jump

  task automatic t_unknown();
    issue(16'h0435, 8'h33);
    chk(17'({insnUnknown, insnRetire, working_register}), 17'h200);
    $display("t_unknown done");
  endtask : t_unknown

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_dec();
    t_skip_zero();
    t_skip_nonzero();
    t_jump();
    t_unknown();
    complete_run();
  end
endmodule : tb_dec_jump_exec
